// [core/sbsr_pkg.sv]
// package for the status byte and service request block: byte indices, bit positions,
// command and bus message encodings, error codes and reset values.
// assumes a single instrument clock; used by the design only, as the bench and checker use literal values.
package sbsr_pkg;

  // ------------------------------------------------------------------
  // status byte and mask indices (1..6, 0 selects all six in a read, none in a mask write)
  // ------------------------------------------------------------------
  localparam logic [2:0] SBSR_IDX_ALL = 3'h0;
  localparam logic [2:0] SBSR_IDX_MAIN = 3'h1;
  localparam logic [2:0] SBSR_IDX_SPARE = 3'h2;
  localparam logic [2:0] SBSR_IDX_SOFTKEY = 3'h3;
  localparam logic [2:0] SBSR_IDX_INTERNAL = 3'h4;
  localparam logic [2:0] SBSR_IDX_OPDONE = 3'h5;
  localparam logic [2:0] SBSR_IDX_ERROR = 3'h6;

  localparam logic [7:0] SBSR_BYTE_RESET = 8'h00;

  // ------------------------------------------------------------------
  // main summary byte bit positions
  // ------------------------------------------------------------------
  localparam int SBSR_MAIN_VALUE_ADAPTED = 0;
  localparam int SBSR_MAIN_SPARE = 1;
  localparam int SBSR_MAIN_SOFTKEY = 2;
  localparam int SBSR_MAIN_INTERNAL = 3;
  localparam int SBSR_MAIN_OPDONE = 4;
  localparam int SBSR_MAIN_ERROR = 5;
  localparam int SBSR_MAIN_REQUEST = 6;
  localparam int SBSR_MAIN_MSG_READY = 7;
  // bits that may raise the request bit
  localparam logic [7:0] SBSR_MAIN_CAUSES = 8'hbf;

  // ------------------------------------------------------------------
  // internal state and operation done bit positions
  // ------------------------------------------------------------------
  localparam int SBSR_INT_STOPPED = 0;
  localparam int SBSR_INT_OVR_ONE = 1;
  localparam int SBSR_INT_OVR_TWO = 2;
  localparam int SBSR_INT_FIRST_SEQ = 3;
  localparam int SBSR_OPD_DUMP = 0;
  localparam int SBSR_OPD_CAL = 2;
  localparam int SBSR_OPD_AVERAGE = 3;

  // ------------------------------------------------------------------
  // soft key codes
  // ------------------------------------------------------------------
  localparam logic [7:0] SBSR_KEY_NONE = 8'h00;
  localparam logic [7:0] SBSR_KEY_FIRST = 8'h01;
  localparam logic [7:0] SBSR_KEY_LAST = 8'h09;
  localparam logic [7:0] SBSR_KEY_HOST_CALL = 8'h0a;

  // ------------------------------------------------------------------
  // commands and bus messages
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBSR_CMD_TAKE = 2'h0,
    SBSR_CMD_PEEK = 2'h1,
    SBSR_CMD_MASK_READ = 2'h2,
    SBSR_CMD_MASK_WRITE = 2'h3
  } sbsr_cmd_t;

  localparam logic [7:0] SBSR_MSG_DEV_CLEAR = 8'h14;
  localparam logic [7:0] SBSR_MSG_SEL_CLEAR = 8'h04;
  localparam logic [7:0] SBSR_MSG_TRIGGER = 8'h08;

  // ------------------------------------------------------------------
  // fault kinds reported by the parser and the error codes they record
  // ------------------------------------------------------------------
  localparam logic [3:0] SBSR_FLT_SEPARATOR = 4'h0;
  localparam logic [3:0] SBSR_FLT_HEADER = 4'h1;
  localparam logic [3:0] SBSR_FLT_NUMBER = 4'h2;
  localparam logic [3:0] SBSR_FLT_KEYWORD = 4'h3;
  localparam logic [3:0] SBSR_FLT_BLOCK = 4'h4;
  localparam logic [3:0] SBSR_FLT_STRINGS = 4'h5;
  localparam logic [3:0] SBSR_FLT_PERMISSION = 4'h6;
  localparam logic [3:0] SBSR_FLT_OPTION = 4'h7;
  localparam logic [3:0] SBSR_FLT_SEMANTIC = 4'h8;
  localparam logic [3:0] SBSR_FLT_ENVIRONMENT = 4'h9;
  localparam logic [3:0] SBSR_FLT_DESCRIPTOR = 4'ha;
  localparam logic [3:0] SBSR_FLT_UNIMPL = 4'hb;

  localparam logic [7:0] SBSR_ERR_NONE = 8'h00;
  localparam logic [7:0] SBSR_ERR_UNREAD = 8'h01;
  localparam logic [7:0] SBSR_ERR_SYNTAX_BASE = 8'h0a;
  localparam logic [7:0] SBSR_ERR_PERMISSION = 8'h14;
  localparam logic [7:0] SBSR_ERR_OPTION = 8'h1e;
  localparam logic [7:0] SBSR_ERR_SEMANTIC = 8'h28;
  localparam logic [7:0] SBSR_ERR_ENVIRONMENT = 8'h32;
  localparam logic [7:0] SBSR_ERR_DESCRIPTOR = 8'h3c;
  localparam logic [7:0] SBSR_ERR_UNIMPL = 8'h64;

endpackage : sbsr_pkg

// [core/sbsr_top.sv]
// status bytes, mask registers and service request summary of the instrument remote port.
// assumes the command parser delivers decoded status and mask commands one at a time and
// that all event inputs are synchronous pulses or levels on clk_sys_i.
module sbsr_top (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // instrument state
  input wire logic remote_i,
  input wire logic single_mode_i,
  input wire logic sequence_trigger_mode_i,
  input wire logic host_call_enabled_i,
  // events
  input wire logic softkey_press_i,
  input wire logic [3:0] softkey_num_i,
  input wire logic host_call_key_i,
  input wire logic acq_stopped_i,
  input wire logic channel_one_overrange_i,
  input wire logic channel_two_overrange_i,
  input wire logic first_seq_trig_i,
  input wire logic dump_done_i,
  input wire logic cal_done_i,
  input wire logic avg_done_i,
  input wire logic value_adapted_i,
  input wire logic message_ready_i,
  input wire logic fault_valid_i,
  input wire logic [3:0] fault_kind_i,
  input wire logic new_cmd_string_i,
  input wire logic responses_pending_i,
  // decoded status and mask commands
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [2:0] cmd_index_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_last_o,
  // bus interface messages
  input wire logic bus_msg_valid_i,
  input wire logic [7:0] bus_msg_code_i,
  // effects
  output logic srq_o,
  output logic rearm_o,
  output logic flush_buffers_o,
  output logic abort_output_o
);

  typedef enum logic {SBSR_IDLE, SBSR_STREAM} sbsr_state_t;

  logic [7:0] main_q;
  logic [7:0] main_d;
  logic [7:0] softkey_code_byte_q;
  logic [7:0] internal_state_byte_q;
  logic [7:0] internal_d;
  logic [7:0] operation_done_byte_q;
  logic [7:0] error_code_byte_q;
  logic [7:0] mask_q [1:6];
  logic first_seq_q;
  sbsr_state_t state_q;
  logic [2:0] cnt_q;
  logic [2:0] last_q;
  logic [1:0] op_q;
  logic ready_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic rsp_last_q;
  logic rearm_q;
  logic flush_q;
  logic abort_q;

  // ------------------------------------------------------------------
  // decode of bus messages and command accept
  // ------------------------------------------------------------------
  logic dev_clear;
  logic accept;
  logic take_clr;
  logic [7:0] key_code;
  logic key_event;
  logic [7:0] err_code;
  logic err_event;
  logic [7:0] opd_set;
  logic [7:0] opd_d;
  logic [7:0] int_rise;
  logic [7:0] opd_rise;
  logic main_rise;

  assign dev_clear = bus_msg_valid_i &&
    (bus_msg_code_i == sbsr_pkg::SBSR_MSG_DEV_CLEAR ||
     bus_msg_code_i == sbsr_pkg::SBSR_MSG_SEL_CLEAR);
  assign accept = cmd_valid_i && ready_q && !dev_clear;
  // a take read clears each byte except the internal state byte in the cycle it is sent out
  assign take_clr = (state_q == SBSR_STREAM) && (op_q == sbsr_pkg::SBSR_CMD_TAKE);

  function automatic logic [7:0] fault_code(input logic [3:0] kind);
    logic [7:0] c;
    c = sbsr_pkg::SBSR_ERR_NONE;
    case (kind)
      sbsr_pkg::SBSR_FLT_SEPARATOR, sbsr_pkg::SBSR_FLT_HEADER, sbsr_pkg::SBSR_FLT_NUMBER,
      sbsr_pkg::SBSR_FLT_KEYWORD, sbsr_pkg::SBSR_FLT_BLOCK, sbsr_pkg::SBSR_FLT_STRINGS: begin
        c = sbsr_pkg::SBSR_ERR_SYNTAX_BASE + {4'h0, kind};
      end
      sbsr_pkg::SBSR_FLT_PERMISSION: c = sbsr_pkg::SBSR_ERR_PERMISSION;
      sbsr_pkg::SBSR_FLT_OPTION: c = sbsr_pkg::SBSR_ERR_OPTION;
      sbsr_pkg::SBSR_FLT_SEMANTIC: c = sbsr_pkg::SBSR_ERR_SEMANTIC;
      sbsr_pkg::SBSR_FLT_ENVIRONMENT: c = sbsr_pkg::SBSR_ERR_ENVIRONMENT;
      sbsr_pkg::SBSR_FLT_DESCRIPTOR: c = sbsr_pkg::SBSR_ERR_DESCRIPTOR;
      sbsr_pkg::SBSR_FLT_UNIMPL: c = sbsr_pkg::SBSR_ERR_UNIMPL;
      default: c = sbsr_pkg::SBSR_ERR_NONE;
    endcase
    return c;
  endfunction : fault_code

  // ------------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------------
  always_comb begin
    key_code = sbsr_pkg::SBSR_KEY_NONE;
    key_event = 1'b0;
    if (softkey_press_i && remote_i && {4'h0, softkey_num_i} >= sbsr_pkg::SBSR_KEY_FIRST &&
        {4'h0, softkey_num_i} <= sbsr_pkg::SBSR_KEY_LAST) begin
      key_code = {4'h0, softkey_num_i};
      key_event = 1'b1;
    end else if (host_call_key_i && !remote_i && host_call_enabled_i) begin
      key_code = sbsr_pkg::SBSR_KEY_HOST_CALL;
      key_event = 1'b1;
    end
  end

  always_comb begin
    err_code = sbsr_pkg::SBSR_ERR_NONE;
    err_event = 1'b0;
    // a parser fault in the same cycle outranks the unread-response code
    if (fault_valid_i && fault_code(fault_kind_i) != sbsr_pkg::SBSR_ERR_NONE) begin
      err_code = fault_code(fault_kind_i);
      err_event = 1'b1;
    end else if (new_cmd_string_i && responses_pending_i) begin
      err_code = sbsr_pkg::SBSR_ERR_UNREAD;
      err_event = 1'b1;
    end
  end

  always_comb begin
    internal_d = sbsr_pkg::SBSR_BYTE_RESET;
    internal_d[sbsr_pkg::SBSR_INT_STOPPED] = acq_stopped_i;
    internal_d[sbsr_pkg::SBSR_INT_OVR_ONE] = channel_one_overrange_i;
    internal_d[sbsr_pkg::SBSR_INT_OVR_TWO] = channel_two_overrange_i;
    internal_d[sbsr_pkg::SBSR_INT_FIRST_SEQ] = first_seq_q || first_seq_trig_i;
  end

  always_comb begin
    opd_set = sbsr_pkg::SBSR_BYTE_RESET;
    opd_set[sbsr_pkg::SBSR_OPD_DUMP] = dump_done_i && remote_i;
    opd_set[sbsr_pkg::SBSR_OPD_CAL] = cal_done_i && remote_i;
    opd_set[sbsr_pkg::SBSR_OPD_AVERAGE] = avg_done_i;
    opd_d = operation_done_byte_q;
    if (dev_clear || (take_clr && (cnt_q == sbsr_pkg::SBSR_IDX_OPDONE))) begin
      opd_d = sbsr_pkg::SBSR_BYTE_RESET;
    end
    opd_d = opd_d | opd_set; // sets win over a clear in the same cycle
  end

  assign int_rise = internal_d & ~internal_state_byte_q & mask_q[sbsr_pkg::SBSR_IDX_INTERNAL];
  assign opd_rise = opd_set & ~operation_done_byte_q & mask_q[sbsr_pkg::SBSR_IDX_OPDONE];

  // ------------------------------------------------------------------
  // main summary byte and request
  // ------------------------------------------------------------------
  always_comb begin
    main_d = main_q;
    if (dev_clear || (take_clr && (cnt_q == sbsr_pkg::SBSR_IDX_MAIN))) begin
      main_d = sbsr_pkg::SBSR_BYTE_RESET;
    end
    if (value_adapted_i) begin
      main_d[sbsr_pkg::SBSR_MAIN_VALUE_ADAPTED] = 1'b1;
    end
    if (key_event && mask_q[sbsr_pkg::SBSR_IDX_SOFTKEY] != sbsr_pkg::SBSR_BYTE_RESET) begin
      main_d[sbsr_pkg::SBSR_MAIN_SOFTKEY] = 1'b1;
    end
    if (int_rise != sbsr_pkg::SBSR_BYTE_RESET) begin
      main_d[sbsr_pkg::SBSR_MAIN_INTERNAL] = 1'b1;
    end
    if (opd_rise != sbsr_pkg::SBSR_BYTE_RESET) begin
      main_d[sbsr_pkg::SBSR_MAIN_OPDONE] = 1'b1;
    end
    if (err_event && mask_q[sbsr_pkg::SBSR_IDX_ERROR] != sbsr_pkg::SBSR_BYTE_RESET) begin
      main_d[sbsr_pkg::SBSR_MAIN_ERROR] = 1'b1;
    end
    main_d[sbsr_pkg::SBSR_MAIN_MSG_READY] = message_ready_i;
    // the request bit stays once pending; it drops only with a clear of this byte
    main_rise = ((main_d & ~main_q & mask_q[sbsr_pkg::SBSR_IDX_MAIN] &
                  sbsr_pkg::SBSR_MAIN_CAUSES) != sbsr_pkg::SBSR_BYTE_RESET);
    if (main_rise) begin
      main_d[sbsr_pkg::SBSR_MAIN_REQUEST] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      main_q <= sbsr_pkg::SBSR_BYTE_RESET;
    end else begin
      main_q <= main_d;
    end
  end

  // ------------------------------------------------------------------
  // lower status bytes
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      softkey_code_byte_q <= sbsr_pkg::SBSR_BYTE_RESET;
      operation_done_byte_q <= sbsr_pkg::SBSR_BYTE_RESET;
      error_code_byte_q <= sbsr_pkg::SBSR_BYTE_RESET;
    end else begin
      if (key_event) begin
        softkey_code_byte_q <= key_code;
      end else if (dev_clear || (take_clr && (cnt_q == sbsr_pkg::SBSR_IDX_SOFTKEY))) begin
        softkey_code_byte_q <= sbsr_pkg::SBSR_BYTE_RESET;
      end
      operation_done_byte_q <= opd_d;
      if (err_event) begin
        error_code_byte_q <= err_code;
      end else if (dev_clear || (take_clr && (cnt_q == sbsr_pkg::SBSR_IDX_ERROR))) begin
        error_code_byte_q <= sbsr_pkg::SBSR_BYTE_RESET;
      end
    end
  end

  // reads and device clear never touch this byte
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      internal_state_byte_q <= sbsr_pkg::SBSR_BYTE_RESET;
      first_seq_q <= 1'b0;
    end else begin
      internal_state_byte_q <= internal_d;
      if (first_seq_trig_i) begin
        first_seq_q <= 1'b1;
      end else if (internal_state_byte_q[sbsr_pkg::SBSR_INT_STOPPED] && !acq_stopped_i) begin
        first_seq_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // mask registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || dev_clear) begin
      for (int i = 1; i <= 6; i++) begin
        mask_q[i] <= sbsr_pkg::SBSR_BYTE_RESET;
      end
    end else if (accept && cmd_op_i == sbsr_pkg::SBSR_CMD_MASK_WRITE &&
                 cmd_index_i >= sbsr_pkg::SBSR_IDX_MAIN &&
                 cmd_index_i <= sbsr_pkg::SBSR_IDX_ERROR) begin
      mask_q[cmd_index_i] <= cmd_data_i;
    end
  end

  // ------------------------------------------------------------------
  // read streaming
  // ------------------------------------------------------------------
  function automatic logic [7:0] status_byte(input logic [2:0] idx);
    logic [7:0] v;
    v = sbsr_pkg::SBSR_BYTE_RESET;
    case (idx)
      sbsr_pkg::SBSR_IDX_MAIN: v = main_q;
      sbsr_pkg::SBSR_IDX_SOFTKEY: v = softkey_code_byte_q;
      sbsr_pkg::SBSR_IDX_INTERNAL: v = internal_state_byte_q;
      sbsr_pkg::SBSR_IDX_OPDONE: v = operation_done_byte_q;
      sbsr_pkg::SBSR_IDX_ERROR: v = error_code_byte_q;
      default: v = sbsr_pkg::SBSR_BYTE_RESET;
    endcase
    return v;
  endfunction : status_byte

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || dev_clear) begin
      state_q <= SBSR_IDLE;
      ready_q <= 1'b1;
      cnt_q <= sbsr_pkg::SBSR_IDX_MAIN;
      last_q <= sbsr_pkg::SBSR_IDX_MAIN;
      op_q <= sbsr_pkg::SBSR_CMD_PEEK;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= sbsr_pkg::SBSR_BYTE_RESET;
      rsp_last_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      rsp_last_q <= 1'b0;
      case (state_q)
        SBSR_IDLE: begin
          if (accept && cmd_op_i != sbsr_pkg::SBSR_CMD_MASK_WRITE &&
              cmd_index_i <= sbsr_pkg::SBSR_IDX_ERROR) begin
            state_q <= SBSR_STREAM;
            ready_q <= 1'b0;
            op_q <= cmd_op_i;
            if (cmd_index_i == sbsr_pkg::SBSR_IDX_ALL) begin
              cnt_q <= sbsr_pkg::SBSR_IDX_MAIN;
              last_q <= sbsr_pkg::SBSR_IDX_ERROR;
            end else begin
              cnt_q <= cmd_index_i;
              last_q <= cmd_index_i;
            end
          end
        end
        SBSR_STREAM: begin
          rsp_valid_q <= 1'b1;
          rsp_last_q <= (cnt_q == last_q);
          if (op_q == sbsr_pkg::SBSR_CMD_MASK_READ) begin
            rsp_data_q <= (cnt_q == sbsr_pkg::SBSR_IDX_ALL) ? sbsr_pkg::SBSR_BYTE_RESET :
                          mask_q[cnt_q];
          end else begin
            rsp_data_q <= status_byte(cnt_q);
          end
          if (cnt_q == last_q) begin
            state_q <= SBSR_IDLE;
            ready_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        default: begin
          state_q <= SBSR_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // one-cycle effect pulses
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rearm_q <= 1'b0;
      flush_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      rearm_q <= bus_msg_valid_i && bus_msg_code_i == sbsr_pkg::SBSR_MSG_TRIGGER &&
                 remote_i && (single_mode_i || sequence_trigger_mode_i);
      flush_q <= dev_clear || (new_cmd_string_i && responses_pending_i);
      abort_q <= dev_clear;
    end
  end

  // the host clears the serviced byte to let a later event request again
  assign srq_o = main_q[sbsr_pkg::SBSR_MAIN_REQUEST];
  assign cmd_ready_o = ready_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o = rsp_data_q;
  assign rsp_last_o = rsp_last_q;
  assign rearm_o = rearm_q;
  assign flush_buffers_o = flush_q;
  assign abort_output_o = abort_q;

endmodule : sbsr_top

// [test/sbsr_asserts.sv]
// checker for sbsr_top: response streams, device clear and trigger effects.
// assumes binding to sbsr_top, one clock and a synchronous active-high reset.
module sbsr_asserts (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic remote_i,
  input wire logic single_mode_i,
  input wire logic sequence_trigger_mode_i,
  input wire logic new_cmd_string_i,
  input wire logic responses_pending_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [2:0] cmd_index_i,
  input wire logic cmd_ready_o,
  input wire logic rsp_valid_o,
  input wire logic rsp_last_o,
  input wire logic bus_msg_valid_i,
  input wire logic [7:0] bus_msg_code_i,
  input wire logic srq_o,
  input wire logic rearm_o,
  input wire logic flush_buffers_o,
  input wire logic abort_output_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // properties
  // ----------
  logic dev_clr, trig, arm_ok, taken, rd_all, rd_one;
  assign dev_clr = bus_msg_valid_i && (bus_msg_code_i == 8'h14 || bus_msg_code_i == 8'h04);
  assign trig = bus_msg_valid_i && bus_msg_code_i == 8'h08;
  assign arm_ok = remote_i && (single_mode_i || sequence_trigger_mode_i);
  // a device clear in the taking cycle wins, so it is excluded here
  assign taken = cmd_valid_i && cmd_ready_o && cmd_op_i != 2'h3 && !dev_clr;
  assign rd_all = taken && cmd_index_i == 3'h0;
  assign rd_one = taken && cmd_index_i != 3'h0 && cmd_index_i != 3'h7;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  reset_idle_a: assert property ($past(reset_i) |->
    cmd_ready_o && !srq_o && !rsp_valid_o)
    else $error("outputs not idle after reset");
  all_six_a: assert property (rd_all |->
    ##2 (rsp_valid_o && !rsp_last_o)[*5] ##1 (rsp_valid_o && rsp_last_o))
    else $error("read of all did not return six bytes");
  one_byte_a: assert property (rd_one |-> ##2 rsp_valid_o && rsp_last_o)
    else $error("single read did not return one byte");
  bad_index_a: assert property (taken && cmd_index_i == 3'h7 |-> ##2 !rsp_valid_o)
    else $error("index seven was answered");
  busy_hold_a: assert property (rsp_valid_o && !rsp_last_o |-> !cmd_ready_o)
    else $error("ready during a stream");
  clear_fx_a: assert property (dev_clr |=> flush_buffers_o && abort_output_o)
    else $error("device clear without flush and abort");
  arm_gate_a: assert property (trig |=> rearm_o == $past(arm_ok))
    else $error("rearm does not follow mode");
  arm_cause_a: assert property (rearm_o |-> $past(trig))
    else $error("rearm without trigger");
  flush_err_a: assert property (new_cmd_string_i && responses_pending_i |=>
    flush_buffers_o)
    else $error("unread responses not flushed");
  cover property (rd_all);
  cover property ($rose(srq_o));
  cover property (rearm_o);
endmodule : sbsr_asserts

bind sbsr_top sbsr_asserts sbsr_asserts_inst (.clk_sys_i, .reset_i, .remote_i, .single_mode_i,
  .sequence_trigger_mode_i, .new_cmd_string_i, .responses_pending_i, .cmd_valid_i, .cmd_op_i,
  .cmd_index_i, .cmd_ready_o, .rsp_valid_o, .rsp_last_o, .bus_msg_valid_i, .bus_msg_code_i,
  .srq_o, .rearm_o, .flush_buffers_o, .abort_output_o);

// [test/sbsr_host_model.sv]
// host controller model: collects every response byte the block returns.
// assumes responses arrive as one-cycle valid strobes on clk_sys_i.
module sbsr_host_model (
  input wire logic clk_sys_i,
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------
  // capture
  // -------
  logic [7:0] rx_q[$];
  // every strobed byte is queued; the bench empties the queue before each read
  always @(posedge clk_sys_i) begin
    if (rsp_valid_i === 1'b1) begin
      rx_q.push_back(rsp_data_i);
    end
  end
endmodule : sbsr_host_model

// [test/tb_status_byte_service_request.sv]
// bench for sbsr_top: events, status and mask commands, bus messages.
// assumes the host model captures response bytes; inputs change 1 ns after an edge.
module tb_status_byte_service_request;
  timeunit 1ns;
  timeprecision 1ps;
  // -----
  // bench
  // -----
  logic clk_sys_i, reset_i, remote_i, single_mode_i, sequence_trigger_mode_i;
  logic host_call_enabled_i, softkey_press_i, host_call_key_i, acq_stopped_i;
  logic channel_one_overrange_i, channel_two_overrange_i, first_seq_trig_i;
  logic dump_done_i, cal_done_i, avg_done_i, value_adapted_i, message_ready_i;
  logic fault_valid_i, new_cmd_string_i, responses_pending_i, cmd_valid_i, bus_msg_valid_i;
  logic cmd_ready_o, rsp_valid_o, rsp_last_o, srq_o, rearm_o, flush_buffers_o, abort_output_o;
  logic [3:0] softkey_num_i, fault_kind_i;
  logic [1:0] cmd_op_i;
  logic [2:0] cmd_index_i;
  logic [7:0] cmd_data_i, bus_msg_code_i, rsp_data_o;
  logic seen;
  int failures = 0;
  int n_checks = 0;
  localparam logic [7:0] ERR_TAB [12] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f,
    8'h14, 8'h1e, 8'h28, 8'h32, 8'h3c, 8'h64};
  sbsr_top sbsr_top_inst (.clk_sys_i, .reset_i, .remote_i, .single_mode_i,
    .sequence_trigger_mode_i, .host_call_enabled_i, .softkey_press_i, .softkey_num_i,
    .host_call_key_i, .acq_stopped_i, .channel_one_overrange_i, .channel_two_overrange_i,
    .first_seq_trig_i, .dump_done_i, .cal_done_i, .avg_done_i, .value_adapted_i,
    .message_ready_i, .fault_valid_i, .fault_kind_i, .new_cmd_string_i, .responses_pending_i,
    .cmd_valid_i, .cmd_op_i, .cmd_index_i, .cmd_data_i, .cmd_ready_o, .rsp_valid_o,
    .rsp_data_o, .rsp_last_o, .bus_msg_valid_i, .bus_msg_code_i, .srq_o, .rearm_o,
    .flush_buffers_o, .abort_output_o);
  sbsr_host_model sbsr_host_model_inst (.clk_sys_i, .rsp_valid_i(rsp_valid_o),
    .rsp_data_i(rsp_data_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask : pulse
  task automatic cmd(input logic [1:0] op, input logic [2:0] idx, input logic [7:0] d);
    for (int i = 0; i < 20 && cmd_ready_o !== 1'b1; i++) step();
    chk({7'h0, cmd_ready_o}, 8'h01, "ready before command");
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_index_i = idx;
    cmd_data_i = d;
    step();
    cmd_valid_i = 1'b0;
    // an idle edge keeps a following command from re-raising valid in this time step
    step();
  endtask : cmd
  task automatic rd(input logic [1:0] op, input logic [2:0] idx, input logic [47:0] exp,
      input string what);
    int n;
    n = (idx == 3'h0) ? 6 : ((idx == 3'h7) ? 0 : 1);
    sbsr_host_model_inst.rx_q.delete();
    cmd(op, idx, 8'h00);
    step(7);
    chk(8'(sbsr_host_model_inst.rx_q.size()), 8'(n), what);
    for (int i = 0; i < n && i < sbsr_host_model_inst.rx_q.size(); i++)
      chk(sbsr_host_model_inst.rx_q[i], exp[8 * (n - 1 - i) +: 8], what);
  endtask : rd
  task automatic complete_run();
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  // the whole sequence needs well under 20 us
  initial begin
    #100us;
    failures++;
    complete_run();
  end
  initial begin
    {reset_i, remote_i, single_mode_i, sequence_trigger_mode_i, host_call_enabled_i,
      softkey_press_i, host_call_key_i, acq_stopped_i, channel_one_overrange_i,
      channel_two_overrange_i, first_seq_trig_i, dump_done_i, cal_done_i, avg_done_i,
      value_adapted_i, message_ready_i, fault_valid_i, new_cmd_string_i, responses_pending_i,
      cmd_valid_i, bus_msg_valid_i, softkey_num_i, fault_kind_i, cmd_op_i, cmd_index_i,
      cmd_data_i, bus_msg_code_i} = '0;
    reset_i = 1'b1;
    step(12);
    reset_i = 1'b0;
    rd(2'h1, 3'h0, 48'h0, "peek after reset");
    rd(2'h2, 3'h0, 48'h0, "masks after reset");
    for (int i = 1; i <= 6; i++) cmd(2'h3, 3'(i), 8'(8'h10 + i));
    cmd(2'h3, 3'h0, 8'hff);
    rd(2'h2, 3'h0, 48'h111213141516, "mask all");
    cmd(2'h3, 3'h2, 8'h00);
    rd(2'h2, 3'h2, 48'h0, "mask zeroed");
    remote_i = 1'b1;
    softkey_num_i = 4'h9;
    pulse(softkey_press_i);
    step();
    softkey_num_i = 4'hc;
    pulse(softkey_press_i);
    rd(2'h0, 3'h3, 48'h09, "key take");
    rd(2'h1, 3'h3, 48'h00, "key cleared");
    remote_i = 1'b0;
    host_call_enabled_i = 1'b1;
    pulse(host_call_key_i);
    rd(2'h1, 3'h3, 48'h0a, "host call");
    acq_stopped_i = 1'b1;
    channel_one_overrange_i = 1'b1;
    pulse(first_seq_trig_i);
    rd(2'h1, 3'h4, 48'h0b, "internal");
    channel_two_overrange_i = 1'b1;
    rd(2'h0, 3'h4, 48'h0f, "internal take");
    rd(2'h1, 3'h4, 48'h0f, "internal kept");
    channel_one_overrange_i = 1'b0;
    acq_stopped_i = 1'b0;
    // the sticky bit 3 drops one cycle after the byte has seen the re-arm
    step();
    rd(2'h1, 3'h4, 48'h04, "internal armed");
    pulse(dump_done_i);
    step();
    remote_i = 1'b1;
    pulse(dump_done_i);
    pulse(cal_done_i);
    pulse(avg_done_i);
    rd(2'h1, 3'h5, 48'h0d, "op done");
    chk({7'h0, srq_o}, 8'h01, "request on op done");
    for (int k = 0; k < 12; k++) begin
      fault_kind_i = 4'(k);
      pulse(fault_valid_i);
      rd(2'h1, 3'h6, {40'h0, ERR_TAB[k]}, "error code");
    end
    responses_pending_i = 1'b1;
    pulse(new_cmd_string_i);
    chk({7'h0, flush_buffers_o}, 8'h01, "flush on unread");
    responses_pending_i = 1'b0;
    rd(2'h1, 3'h6, 48'h01, "unread code");
    rd(2'h0, 3'h0, 48'h7c000a040d01, "take all");
    rd(2'h1, 3'h0, 48'h000000040000, "after take");
    chk({7'h0, srq_o}, 8'h00, "request after take");
    message_ready_i = 1'b1;
    rd(2'h1, 3'h1, 48'h80, "message ready");
    message_ready_i = 1'b0;
    rd(2'h1, 3'h7, 48'h0, "index seven");
    for (int k = 0; k < 2; k++) begin
      cmd(2'h3, 3'h1, 8'h01);
      pulse(value_adapted_i);
      chk({7'h0, srq_o}, 8'h01, "request raised");
      bus_msg_code_i = (k == 0) ? 8'h14 : 8'h04;
      pulse(bus_msg_valid_i);
      chk({6'h0, flush_buffers_o, abort_output_o}, 8'h03, "clear effects");
      step();
      chk({7'h0, srq_o}, 8'h00, "request after clear");
      rd(2'h1, 3'h0, 48'h000000040000, "bytes after clear");
      rd(2'h2, 3'h0, 48'h0, "masks after clear");
    end
    for (int k = 0; k < 8; k++) begin
      {remote_i, single_mode_i, sequence_trigger_mode_i} = 3'(k);
      bus_msg_code_i = 8'h08;
      pulse(bus_msg_valid_i);
      seen = rearm_o;
      step();
      seen = seen | rearm_o;
      chk({7'h0, seen}, 8'(k > 4), "rearm");
    end
    complete_run();
  end
endmodule : tb_status_byte_service_request
